// File: shared/fpcf_pkg.sv
// Purpose: Shared constants and types for the flash command interpreter.
// Assumes: 16-bit word bus, top four address bits select the bank.
// Notes: Identity values are arbitrary.
package fpcf_pkg;
   localparam int ARR_W = 6;
   localparam int BUF_N = 32;
   localparam logic [11:0] OFS_UNL1 = 12'h555;
   localparam logic [11:0] OFS_UNL2 = 12'h2aa;
   localparam logic [15:0] CMD_UNL1 = 16'h00aa;
   localparam logic [15:0] CMD_UNL2 = 16'h0055;
   localparam logic [15:0] CMD_ASEL = 16'h0090;
   localparam logic [15:0] CMD_RST = 16'h00f0;
   localparam logic [15:0] CMD_PROG = 16'h00a0;
   localparam logic [15:0] CMD_BLOAD = 16'h0025;
   localparam logic [15:0] CMD_BCONF = 16'h0029;
   localparam logic [15:0] CMD_SUSP = 16'h00b0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] MAX_CNT = 16'h001f;
   localparam int BIT_POLL = 7;
   localparam int BIT_TOG = 6;
   localparam int BIT_EXC = 5;
   localparam int BIT_ALT = 2;
   localparam int BIT_ABT = 1;
   localparam logic [9:0] PROG_CYC = 10'h010;
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_STAT = 8'h04;
   localparam logic [7:0] WB_LAST = 8'h08;
   localparam logic SYNC_RST = 1'b0;
   // Arbitrary identity values.
   localparam logic [15:0] MAKER_ID = 16'h0a5a;
   localparam logic [15:0] PART_ID = 16'h0c3c;
   typedef enum logic [3:0] {
      ST_READ, ST_UNL1, ST_UNL2, ST_PDATA, ST_BCNT, ST_BLOAD,
      ST_BCONF, ST_BUSY, ST_ABORT, ST_EXCEED, ST_ASEL
   } fpcf_st_type;
   typedef struct packed {
      logic avd_n;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [15:0] addr;
      logic [15:0] dq;
   } fpcf_pins_type;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } fpcf_wb_type;
   typedef struct packed {
      fpcf_st_type st;
      logic sync_mode;
      logic p_avd_n;
      logic p_wr;
      logic p_rd;
      logic [15:0] p_dq;
      logic [15:0] lat_addr;
      logic [3:0] bank;
      logic [10:0] page;
      logic page_set;
      logic [4:0] remain;
      logic is_buf;
      logic susp;
      logic [9:0] cnt;
      logic [1:0] unl;
      logic [15:0] last_addr;
      logic [15:0] last_data;
      logic tog;
      logic abt;
      logic exc;
      logic [15:0] dq_out;
      logic dq_oe;
      logic ack;
      logic [31:0] rdat;
      logic [BUF_N-1:0] bufv;
      logic [BUF_N-1:0][15:0] bufd;
      logic [(1<<ARR_W)-1:0][15:0] arr;
   } fpcf_state_type;
endpackage : fpcf_pkg

// File: src/fpcf_top.sv
// Purpose: Command interpreter for program, buffer program and autoselect.
// Assumes: Pin inputs are synchronous to CLK; the array is a small model.
// Notes: Registers on classic Wishbone select write mode and show status.
`timescale 1ns/1ns
module fpcf_top
   import fpcf_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RSTN,
   // Flash pins.
   input wire fpcf_pins_type PINS,
   output logic [15:0] DQ_O,
   output logic DQ_OE,
   // Wishbone slave.
   input wire fpcf_wb_type WB_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);
   function automatic logic [ARR_W-1:0] arr_index(input logic [15:0] a);
      return a[ARR_W-1:0];
   endfunction : arr_index

   fpcf_state_type st_ff;
   fpcf_state_type nxt_st;
   logic cap_avd;
   logic wr_lvl;
   logic rd_lvl;
   logic wr_ev;
   logic [15:0] cmd_addr;
   logic [15:0] cmd_data;
   logic [11:0] off;
   logic bank_ok;

   assign wr_lvl = !PINS.ce_n && !PINS.we_n && PINS.oe_n;
   assign rd_lvl = !PINS.ce_n && !PINS.oe_n && PINS.we_n;
   assign cap_avd = st_ff.sync_mode ? (!PINS.avd_n && !PINS.ce_n && PINS.oe_n)
                                    : (!st_ff.p_avd_n && PINS.avd_n);
   // Asynchronous mode: the first rising edge of either strobe ends the low overlap; synchronous mode: the write is taken when it begins.
   assign wr_ev = st_ff.sync_mode ? (wr_lvl && !st_ff.p_wr)
                                  : (st_ff.p_wr && !wr_lvl);
   assign cmd_addr = cap_avd ? PINS.addr : st_ff.lat_addr;
   assign cmd_data = st_ff.sync_mode ? PINS.dq : st_ff.p_dq;
   assign off = cmd_addr[11:0];
   assign bank_ok = cmd_addr[15:12] == st_ff.bank;

   always_comb begin
      logic ab;
      logic viol;
      logic [15:0] ba;
      ab = 1'b0;
      viol = 1'b0;
      ba = 16'h0000;
      nxt_st = st_ff;
      nxt_st.p_avd_n = PINS.avd_n;
      nxt_st.p_wr = !PINS.ce_n && !PINS.we_n;
      nxt_st.p_rd = rd_lvl;
      nxt_st.p_dq = PINS.dq;
      if (cap_avd) begin
         nxt_st.lat_addr = PINS.addr;
      end
      if (wr_ev) begin
         unique case (st_ff.st)
            ST_READ: begin
               if (cmd_data == CMD_UNL1 && off == OFS_UNL1) begin
                  nxt_st.st = ST_UNL1;
                  nxt_st.bank = cmd_addr[15:12];
               end
            end
            ST_UNL1: begin
               nxt_st.st = (cmd_data == CMD_UNL2 && off == OFS_UNL2 && bank_ok)
                           ? ST_UNL2 : ST_READ;
            end
            ST_UNL2: begin
               nxt_st.st = ST_READ;
               if (cmd_data == CMD_ASEL && off == OFS_UNL1 && bank_ok) begin
                  nxt_st.st = ST_ASEL;
               end else if (cmd_data == CMD_PROG && off == OFS_UNL1 && bank_ok) begin
                  nxt_st.st = ST_PDATA;
               end else if (cmd_data == CMD_BLOAD) begin
                  nxt_st.st = ST_BCNT;
                  nxt_st.bank = cmd_addr[15:12];
               end
            end
            ST_PDATA: begin
               // Any address is taken, sector boundaries do not matter.
               nxt_st.last_addr = cmd_addr;
               nxt_st.last_data = cmd_data;
               nxt_st.cnt = PROG_CYC;
               nxt_st.is_buf = 1'b0;
               nxt_st.susp = 1'b0;
               nxt_st.st = ST_BUSY;
            end
            ST_BCNT: begin
               if (!bank_ok || cmd_data > MAX_CNT) begin
                  ab = 1'b1;
               end else begin
                  nxt_st.remain = cmd_data[4:0];
                  nxt_st.page_set = 1'b0;
                  nxt_st.bufv = '0;
                  nxt_st.st = ST_BLOAD;
               end
            end
            ST_BLOAD: begin
               if (!bank_ok || (st_ff.page_set && cmd_addr[15:5] != st_ff.page)) begin
                  ab = 1'b1;
               end else begin
                  nxt_st.page = cmd_addr[15:5];
                  nxt_st.page_set = 1'b1;
                  nxt_st.bufd[cmd_addr[4:0]] = cmd_data;
                  nxt_st.bufv[cmd_addr[4:0]] = 1'b1;
                  nxt_st.last_addr = cmd_addr;
                  nxt_st.last_data = cmd_data;
                  if (st_ff.remain == 5'h00) begin
                     nxt_st.st = ST_BCONF;
                  end else begin
                     nxt_st.remain = st_ff.remain - 5'h01;
                  end
               end
            end
            ST_BCONF: begin
               if (cmd_data == CMD_BCONF && bank_ok) begin
                  nxt_st.cnt = 10'($countones(st_ff.bufv)) * PROG_CYC;
                  nxt_st.is_buf = 1'b1;
                  nxt_st.susp = 1'b0;
                  nxt_st.st = ST_BUSY;
               end else begin
                  ab = 1'b1;
               end
            end
            ST_BUSY: begin
               // Only suspend and resume act here; autoselect cannot start.
               if (cmd_data == CMD_SUSP) begin
                  nxt_st.susp = 1'b1;
               end else if (cmd_data == CMD_RESUME) begin
                  nxt_st.susp = 1'b0;
               end
            end
            ST_ABORT: begin
               // A plain reset is not enough after an abort.
               nxt_st.unl = 2'b00;
               if (st_ff.unl == 2'b00 && cmd_data == CMD_UNL1 && off == OFS_UNL1) begin
                  nxt_st.unl = 2'b01;
               end else if (st_ff.unl == 2'b01 && cmd_data == CMD_UNL2
                            && off == OFS_UNL2) begin
                  nxt_st.unl = 2'b10;
               end else if (st_ff.unl == 2'b10 && cmd_data == CMD_RST
                            && off == OFS_UNL1) begin
                  nxt_st.st = ST_READ;
                  nxt_st.abt = 1'b0;
               end
            end
            ST_EXCEED: begin
               if (cmd_data == CMD_RST) begin
                  nxt_st.st = ST_READ;
                  nxt_st.exc = 1'b0;
               end
            end
            ST_ASEL: begin
               if (cmd_data == CMD_RST) begin
                  nxt_st.st = ST_READ;
               end
            end
            default: begin
               nxt_st.st = ST_READ;
            end
         endcase
      end
      if (ab) begin
         nxt_st.st = ST_ABORT;
         nxt_st.abt = 1'b1;
         nxt_st.exc = 1'b0;
         nxt_st.unl = 2'b00;
      end
      if (st_ff.st == ST_BUSY && !st_ff.susp) begin
         if (st_ff.cnt != 10'h000) begin
            nxt_st.cnt = st_ff.cnt - 10'h001;
         end else begin
            if (st_ff.is_buf) begin
               for (int i = 0; i < BUF_N; i++) begin
                  ba = {st_ff.page, 5'(i)};
                  if (st_ff.bufv[i] && |(st_ff.bufd[i] & ~st_ff.arr[arr_index(ba)])) begin
                     viol = 1'b1;
                  end
               end
               for (int i = 0; i < BUF_N; i++) begin
                  ba = {st_ff.page, 5'(i)};
                  if (st_ff.bufv[i] && !viol) begin
                     nxt_st.arr[arr_index(ba)] = st_ff.bufd[i];
                  end
               end
            end else begin
               viol = |(st_ff.last_data & ~st_ff.arr[arr_index(st_ff.last_addr)]);
               if (!viol) begin
                  nxt_st.arr[arr_index(st_ff.last_addr)] = st_ff.last_data;
               end
            end
            // A 1 over a stored 0 leaves the cell alone and halts.
            nxt_st.st = viol ? ST_EXCEED : ST_READ;
            nxt_st.exc = viol;
            nxt_st.lat_addr = 16'h0000;
         end
      end
      if (rd_lvl && !st_ff.p_rd) begin
         nxt_st.tog = !st_ff.tog;
      end
      nxt_st.dq_oe = rd_lvl;
      if (st_ff.st == ST_BUSY || st_ff.st == ST_ABORT || st_ff.st == ST_EXCEED) begin
         nxt_st.dq_out = 16'h0000;
         nxt_st.dq_out[BIT_POLL] = !st_ff.last_data[7];
         nxt_st.dq_out[BIT_TOG] = st_ff.tog;
         nxt_st.dq_out[BIT_EXC] = st_ff.exc;
         nxt_st.dq_out[BIT_ALT] = st_ff.tog;
         nxt_st.dq_out[BIT_ABT] = st_ff.abt;
      end else if (st_ff.st == ST_ASEL && PINS.addr[15:12] == st_ff.bank) begin
         nxt_st.dq_out = PINS.addr[3:0] == 4'h0 ? MAKER_ID
                       : PINS.addr[3:0] == 4'h1 ? PART_ID : 16'h0000;
      end else begin
         nxt_st.dq_out = st_ff.arr[arr_index(PINS.addr)];
      end
      nxt_st.ack = WB_I.cyc && WB_I.stb && !st_ff.ack;
      if (WB_I.cyc && WB_I.stb && !st_ff.ack) begin
         if (WB_I.we && WB_I.adr == WB_CTRL && WB_I.sel[0]) begin
            nxt_st.sync_mode = WB_I.dat[0];
         end
         unique case (WB_I.adr)
            WB_CTRL: nxt_st.rdat = {31'h00000000, st_ff.sync_mode};
            WB_STAT: nxt_st.rdat = {20'h00000, st_ff.st, 3'h0, st_ff.st == ST_ASEL,
                                    st_ff.susp, st_ff.exc, st_ff.abt,
                                    st_ff.st == ST_BUSY};
            WB_LAST: nxt_st.rdat = {16'h0000, st_ff.last_addr};
            default: nxt_st.rdat = 32'h00000000;
         endcase
      end
   end

   // Reset clears every operation in flight at once.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_ff <= '0;
         st_ff.st <= ST_READ;
         st_ff.sync_mode <= SYNC_RST;
         st_ff.p_avd_n <= 1'b1;
         st_ff.arr <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign DQ_O = st_ff.dq_out;
   assign DQ_OE = st_ff.dq_oe;
   assign WB_DAT_O = st_ff.rdat;
   assign WB_ACK_O = st_ff.ack;

   a_asel_entry: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_UNL2 && wr_ev && cmd_data == CMD_ASEL && off == OFS_UNL1
      && bank_ok |=> st_ff.st == ST_ASEL)
      else $error("autoselect entry missed");
   a_asel_exit: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_ASEL && wr_ev && cmd_data == CMD_RST |=> st_ff.st == ST_READ)
      else $error("autoselect exit missed");
   a_busy_ignore: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BUSY |=> st_ff.st inside {ST_BUSY, ST_READ, ST_EXCEED})
      else $error("command accepted while busy");
   a_exceed_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_EXCEED && !(wr_ev && cmd_data == CMD_RST)
      |=> st_ff.st == ST_EXCEED && st_ff.exc)
      else $error("exceeded state left early");
   a_count_abort: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BCNT && wr_ev && cmd_data > MAX_CNT |=> st_ff.st == ST_ABORT)
      else $error("oversize count not aborted");
   a_page_abort: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BLOAD && wr_ev && st_ff.page_set
      && cmd_addr[15:5] != st_ff.page |=> st_ff.st == ST_ABORT)
      else $error("page change not aborted");
   a_load_count: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BLOAD && wr_ev && bank_ok
      && (!st_ff.page_set || cmd_addr[15:5] == st_ff.page)
      && st_ff.remain != 5'h00 |=> st_ff.remain == $past(st_ff.remain) - 5'h01)
      else $error("load counter not decremented");
   a_confirm_bad: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BCONF && wr_ev && cmd_data != CMD_BCONF |=> st_ff.st == ST_ABORT)
      else $error("bad confirm not aborted");
   a_abort_bits: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_ABORT && rd_lvl ##1 st_ff.st == ST_ABORT
      |-> st_ff.dq_out[BIT_ABT] && !st_ff.dq_out[BIT_EXC]
      && st_ff.dq_out[BIT_POLL] == !st_ff.last_data[7])
      else $error("abort status bits wrong");
   a_done_release: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BUSY ##1 st_ff.st == ST_READ |-> st_ff.lat_addr == 16'h0000)
      else $error("address held after program");
   a_susp_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      st_ff.st == ST_BUSY && st_ff.susp |=> $stable(st_ff.cnt))
      else $error("countdown ran while suspended");
endmodule : fpcf_top

// File: test/fpcf_host.sv
// Purpose: Host model that issues flash command writes and status reads.
// Assumes: One strobe pulse per write, strobes high a cycle between writes.
// Notes: Write address and data lines whose hold time is over show inverted values, so stale data never passes.
`timescale 1ns/1ns
module fpcf_host
   import fpcf_pkg::*;
(
   // Clock and device answer.
   input wire logic clk,
   input wire logic [15:0] dq_o,
   input wire logic dq_oe,
   // Device pins.
   output fpcf_pins_type pins
);
   logic sync_mode = 1'b0;
   initial pins = {4'hf, 32'h0};
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      pins.addr <= a;
      pins.avd_n <= 1'b0;
      pins.ce_n <= ~sync_mode;
      @(posedge clk);
      pins.avd_n <= 1'b1;
      pins.ce_n <= 1'b1;
      @(posedge clk);
      pins.addr <= ~a;
      pins.ce_n <= 1'b0;
      pins.we_n <= 1'b0;
      pins.dq <= d;
      @(posedge clk);
      pins.ce_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.dq <= ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic oe);
      @(posedge clk);
      pins.addr <= a;
      pins.avd_n <= 1'b0;
      pins.ce_n <= 1'b0;
      @(posedge clk);
      pins.avd_n <= 1'b1;
      @(posedge clk);
      pins.oe_n <= 1'b0;
      repeat (2) @(posedge clk);
      d = dq_o;
      oe = dq_oe;
      pins.ce_n <= 1'b1;
      pins.oe_n <= 1'b1;
   endtask : rd
   task automatic unl(input logic [3:0] b);
      wr({b, OFS_UNL1}, CMD_UNL1);
      wr({b, OFS_UNL2}, CMD_UNL2);
   endtask : unl
endmodule : fpcf_host

// File: test/fpcf_top_tb_top.sv
// Purpose: Self-checking bench for the flash command interpreter.
// Assumes: The host model drives the pins; status is read over Wishbone.
// Notes: The array model is 64 words and aliases the same way as the design.
`timescale 1ns/1ns
module fpcf_top_tb_top
   import fpcf_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   fpcf_pins_type pins;
   fpcf_wb_type wb = '0;
   logic [15:0] dq_o, rv, s1, s2, d1, d2;
   logic dq_oe, ack, oe;
   logic [31:0] wdo, wv;
   logic [3:0] sel_clr = 4'h0;
   int n_mismatch = 0;
   int n_tests = 0;
   int mem [64];
   int o;
   always #10 clk = ~clk;
   fpcf_top u_fpcf_top (.CLK(clk), .RSTN(rstn), .PINS(pins), .DQ_O(dq_o), .DQ_OE(dq_oe),
      .WB_I(wb), .WB_DAT_O(wdo), .WB_ACK_O(ack));
   fpcf_host u_host (.clk(clk), .dq_o(dq_o), .dq_oe(dq_oe), .pins(pins));
   task automatic end_sim();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: (4'($urandom) | 4'h1) & ~sel_clr,
              adr: a, dat: w ? d : 32'($urandom)};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      wv = wdo;
      wb <= '0;
      if (ack !== 1'b1) begin
         n_mismatch++;
         end_sim();
      end
   endtask : wbx
   task automatic idle();
      int i;
      for (i = 0; i < 400; i++) begin
         wbx(1'b0, WB_STAT, 32'h0);
         if (wv[0] === 1'b0) begin
            return;
         end
      end
      n_mismatch++;
      end_sim();
   endtask : idle
   initial begin
      void'($urandom(74));
      foreach (mem[i]) begin
         mem[i] = 16'hffff;
      end
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      wbx(1'b1, WB_STAT, 32'hffff_ffff);
      wbx(1'b0, WB_STAT, 32'h0);
      chk("status", 32'h0, wv);
      wbx(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 32'h0, wv);
      sel_clr = 4'h1;
      wbx(1'b1, WB_CTRL, 32'h1);
      sel_clr = 4'h0;
      wbx(1'b0, WB_CTRL, 32'h0);
      chk("ctrl_sel", 32'h0, wv);
      // Word program; commands written meanwhile must not take effect.
      d1 = 16'($urandom) & 16'hfffe;
      u_host.unl(4'h3);
      u_host.wr(16'h3555, CMD_PROG);
      u_host.wr(16'h3012, d1);
      mem[18] = d1;
      u_host.rd(16'h3012, rv, oe);
      chk("dq_oe", 1'b1, oe);
      chk("poll", {~d1[7]}, rv[7]);
      u_host.unl(4'h3);
      u_host.wr(16'h3555, CMD_ASEL);
      idle();
      wbx(1'b0, WB_STAT, 32'h0);
      chk("state", 12'h000, wv[11:0]);
      u_host.rd(16'h3012, rv, oe);
      chk("word", mem[18], rv);
      wbx(1'b0, WB_LAST, 32'h0);
      chk("last", 16'h3012, wv[15:0]);
      // A one over a zero halts until the reset command.
      u_host.unl(4'h3);
      u_host.wr(16'h3555, CMD_PROG);
      u_host.wr(16'h3012, d1 | 16'h0001);
      idle();
      wbx(1'b0, WB_STAT, 32'h0);
      chk("exceed", 12'h904, wv[11:0]);
      u_host.rd(16'h3012, rv, oe);
      chk("exc_bit", 1'b1, rv[5]);
      u_host.wr(16'hb7c3, CMD_RST);
      u_host.rd(16'h3012, rv, oe);
      chk("kept", mem[18], rv);
      u_host.unl(4'h5);
      u_host.wr(16'h5555, CMD_ASEL);
      u_host.rd(16'h5000, rv, oe);
      chk("maker", MAKER_ID, rv);
      u_host.rd(16'h5001, rv, oe);
      chk("part", PART_ID, rv);
      u_host.wr(16'h9abc, CMD_RST);
      u_host.rd(16'h5012, rv, oe);
      chk("asel_exit", mem[18], rv);
      // Full buffer in synchronous mode, with one location loaded twice.
      wbx(1'b1, WB_CTRL, 32'h1);
      wbx(1'b0, WB_CTRL, 32'h0);
      chk("ctrl", 32'h1, wv);
      u_host.sync_mode = 1'b1;
      u_host.unl(4'h7);
      u_host.wr(16'h7000, CMD_BLOAD);
      u_host.wr(16'h7000, MAX_CNT);
      for (int i = 0; i < 32; i++) begin
         o = (i == 31) ? 0 : i;
         d2 = 16'($urandom);
         u_host.wr({11'h381, 5'(o)}, d2);
         mem[32 + o] = d2;
      end
      u_host.wr(16'h7000, CMD_BCONF);
      u_host.rd(16'h7020, s1, oe);
      u_host.rd(16'h7020, s2, oe);
      chk("poll_buf", {~d2[7]}, s1[7]);
      chk("toggle", {~s1[6], ~s1[2]}, {s2[6], s2[2]});
      idle();
      for (int i = 0; i < 32; i++) begin
         u_host.rd({11'h381, 5'(i)}, rv, oe);
         chk("buf_word", mem[32 + i], rv);
      end
      // Four ways of breaking the buffer sequence (oversize count, wrong bank, page change, bad confirm), each left by the abort reset.
      wbx(1'b1, WB_CTRL, 32'h0);
      u_host.sync_mode = 1'b0;
      for (int k = 0; k < 4; k++) begin
         // The top bit keeps the stray data word apart from the confirm code.
         d2 = 16'($urandom) | 16'h8000;
         u_host.unl(4'h2);
         u_host.wr(16'h2000, CMD_BLOAD);
         u_host.wr(16'h2000, (k == 0) ? 16'h0020 : 16'h0001);
         if (k > 0) begin
            u_host.wr(16'h2040, d2);
            u_host.wr((k == 1) ? 16'h3041 : (k == 2) ? 16'h2061 : 16'h2041, d2);
         end
         if (k == 3) begin
            u_host.wr(16'h2041, d2);
         end
         wbx(1'b0, WB_STAT, 32'h0);
         chk("abort", 12'h802, wv[11:0]);
         u_host.rd(16'h2040, s1, oe);
         u_host.rd(16'h2040, s2, oe);
         chk("abort_word", 3'b101, {s1[6] ^ s2[6], s1[5], s1[1]});
         if (k > 0) begin
            chk("abort_poll", {~d2[7]}, s1[7]);
         end
         u_host.unl(4'h2);
         u_host.wr(16'h2555, CMD_RST);
         wbx(1'b0, WB_STAT, 32'h0);
         chk("abort_exit", 12'h000, wv[11:0]);
      end
      // Hardware reset in mid-program, then the program written again.
      u_host.unl(4'h1);
      u_host.wr(16'h1555, CMD_PROG);
      u_host.wr(16'h1015, 16'h0000);
      repeat (3) @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (mem[i]) begin
         mem[i] = 16'hffff;
      end
      wbx(1'b0, WB_STAT, 32'h0);
      chk("hw_reset", 32'h0, wv);
      u_host.rd(16'h1015, rv, oe);
      chk("hw_word", mem[21], rv);
      d1 = 16'($urandom);
      u_host.unl(4'h1);
      u_host.wr(16'h1555, CMD_PROG);
      u_host.wr(16'h1015, d1);
      u_host.wr(16'h1555, CMD_SUSP);
      wbx(1'b0, WB_STAT, 32'h0);
      chk("suspend", 12'h709, wv[11:0]);
      u_host.wr(16'h1555, CMD_RESUME);
      idle();
      u_host.rd(16'h1015, rv, oe);
      chk("reissue", d1, rv);
      end_sim();
   end
endmodule : fpcf_top_tb_top
